/* src/axis_interrupt_output_logic.sv */
// two-axis interrupt aggregation: flags, main status bits and shared interrupt pin
// assumes commands, setting writes and status reads come from the command interface
// as one-cycle pulses on ref_clk_in; cause pulses come from same-clock axis logic
`include "axis_irq_defines.svh"
module axis_interrupt_output_logic (
  input  wire logic                        ref_clk_in,
  input  wire logic                        arst_n_in,
  input  wire logic [`AXES-1:0]            axis_sel_in,
  input  wire logic                        cmd_valid_in,
  input  wire logic [`CMD_W-1:0]           cmd_code_in,
  input  wire logic [31:0]                 buf_in,
  input  wire logic [`AXES-1:0]            env1_write_in,
  input  wire logic [`AXES-1:0]            env2_write_in,
  input  wire logic [`AXES-1:0]            prmd_write_in,
  input  wire logic [`AXES-1:0]            axis_main_status_word_read_in,
  input  wire logic [`AXES*`ERR_W-1:0]     err_set_in,
  input  wire logic [`AXES*`EVT_W-1:0]     evt_set_in,
  input  wire logic [`AXES-1:0]            axis_operating_out_in,
  input  wire logic [`AXES-1:0]            next_op_queued_in,
  input  wire logic [`AXES-1:0]            start_written_in,
  output logic                             irq_n_out,
  output logic                             buf_load_out,
  output logic [31:0]                      buf_data_out,
  output logic [`AXES*`AXIS_MAIN_STATUS_WORD_W-1:0]         axis_main_status_word_out
);
  logic [`AXES-1:0] mask_bit;
  logic [`AXES-1:0] stop_en_bit;
  logic [`AXES-1:0] suppr_bit;
  logic [`AXES-1:0] prev_oper;
  logic [`AXES-1:0] next_mask_bit;
  logic [`AXES-1:0] next_stop_en_bit;
  logic [`AXES-1:0] next_suppr_bit;
  logic [`AXES-1:0] stop_flag;
  logic [`AXES-1:0] err_flag;
  logic [`AXES-1:0] evt_flag;
  logic [`AXES-1:0] rd_err;
  logic [`AXES-1:0] rd_evt;
  logic [`AXES-1:0] wr_en;
  logic [`AXES-1:0] stop_event;
  logic [`AXES-1:0] suppress;
  axis_irq_pkg::err_vec_t err_cause [`AXES];
  axis_irq_pkg::evt_vec_t evt_cause [`AXES];
  logic                   irq_n;
  logic                   buf_load;
  logic [31:0]            buf_data;
  logic [`AXES*`AXIS_MAIN_STATUS_WORD_W-1:0] axis_main_status_word;
  logic                   next_irq_n;
  logic                   next_buf_load;
  logic [31:0]            next_buf_data;
  logic [`AXES*`AXIS_MAIN_STATUS_WORD_W-1:0] next_axis_main_status_word;
  logic                   any_pending;

  // strobe and code are passed in so that continuous assigns re-evaluate on them
  function automatic logic is_cmd(input logic              valid,
                                  input logic [`CMD_W-1:0] code,
                                  input logic [`CMD_W-1:0] want);
    is_cmd = valid && (code == want);
  endfunction

  genvar g;
  generate
    for (g = 0; g < `AXES; g++) begin : g_axis
      assign rd_err[g] = is_cmd(cmd_valid_in, cmd_code_in, `CMD_READ_ERR) && axis_sel_in[g];
      assign rd_evt[g] = is_cmd(cmd_valid_in, cmd_code_in, `CMD_READ_EVT) && axis_sel_in[g];
      assign wr_en[g]  = is_cmd(cmd_valid_in, cmd_code_in, `CMD_WRITE_EN) && axis_sel_in[g];
      // operating to stopped transition
      assign stop_event[g] = prev_oper[g] && !axis_operating_out_in[g];
      // suppression only applies once a start has been queued
      assign suppress[g] = suppr_bit[g] && next_op_queued_in[g] && start_written_in[g];

      axis_irq_channel u_chan (
        .ref_clk_in      (ref_clk_in),
        .arst_n_in       (arst_n_in),
        .err_set_in      (err_set_in[g*`ERR_W +: `ERR_W]),
        .evt_set_in      (evt_set_in[g*`EVT_W +: `EVT_W]),
        .stop_event_in   (stop_event[g]),
        .stop_en_in      (stop_en_bit[g]),
        .suppress_in     (suppress[g]),
        .cmd_read_err_in (rd_err[g]),
        .cmd_read_evt_in (rd_evt[g]),
        .cmd_write_en_in (wr_en[g]),
        .axis_main_status_word_read_in    (axis_main_status_word_read_in[g]),
        .buf_in          (buf_in[`EVT_W-1:0]),
        .stop_flag_out   (stop_flag[g]),
        .err_flag_out    (err_flag[g]),
        .evt_flag_out    (evt_flag[g]),
        .err_cause_out   (err_cause[g]),
        .evt_cause_out   (evt_cause[g]),
        .evt_enable_out  ()
      );
    end
  endgenerate

  always_comb begin
    next_mask_bit    = mask_bit;
    next_stop_en_bit = stop_en_bit;
    next_suppr_bit   = suppr_bit;
    for (int i = 0; i < `AXES; i++) begin
      if (env1_write_in[i]) begin
        next_mask_bit[i] = buf_in[`ENV1_MASK_BIT];
      end
      if (env2_write_in[i]) begin
        next_stop_en_bit[i] = buf_in[`ENV2_STOP_EN_BIT];
      end
      if (prmd_write_in[i]) begin
        next_suppr_bit[i] = buf_in[`PRMD_SUPPR_BIT];
      end
    end
  end

  always_comb begin
    next_axis_main_status_word = '0;
    for (int i = 0; i < `AXES; i++) begin
      next_axis_main_status_word[i*`AXIS_MAIN_STATUS_WORD_W + `AXIS_MAIN_STATUS_WORD_STOP_BIT] = stop_flag[i];
      next_axis_main_status_word[i*`AXIS_MAIN_STATUS_WORD_W + `AXIS_MAIN_STATUS_WORD_ERR_BIT]  = err_flag[i];
      next_axis_main_status_word[i*`AXIS_MAIN_STATUS_WORD_W + `AXIS_MAIN_STATUS_WORD_EVT_BIT]  = evt_flag[i];
    end
    any_pending = |(stop_flag | err_flag | evt_flag);
    // the shared pin follows the mask of the first axis, so status still updates
    next_irq_n = !(any_pending && !mask_bit[0]);
    next_buf_load = 1'b0;
    next_buf_data = buf_data;
    for (int i = 0; i < `AXES; i++) begin
      if (rd_err[i]) begin
        next_buf_load = 1'b1;
        next_buf_data = {{(32-`ERR_W){1'b0}}, err_cause[i]};
      end else if (rd_evt[i]) begin
        next_buf_load = 1'b1;
        next_buf_data = {{(32-`EVT_W){1'b0}}, evt_cause[i]};
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mask_bit    <= '0;
      stop_en_bit <= '0;
      suppr_bit   <= '0;
      prev_oper   <= '0;
      irq_n       <= 1'b1;
      buf_load    <= 1'b0;
      buf_data    <= '0;
      axis_main_status_word        <= '0;
    end else begin
      mask_bit    <= next_mask_bit;
      stop_en_bit <= next_stop_en_bit;
      suppr_bit   <= next_suppr_bit;
      prev_oper   <= axis_operating_out_in;
      irq_n       <= next_irq_n;
      buf_load    <= next_buf_load;
      buf_data    <= next_buf_data;
      axis_main_status_word        <= next_axis_main_status_word;
    end
  end

  assign irq_n_out                 = irq_n;
  assign buf_load_out              = buf_load;
  assign buf_data_out              = buf_data;
  assign axis_main_status_word_out = axis_main_status_word;
endmodule

/* src/axis_irq_defines.svh */
// constants for the two-axis interrupt output logic
// assumes inclusion by bare name from the package and the design modules
`ifndef AXIS_IRQ_DEFINES_SVH
`define AXIS_IRQ_DEFINES_SVH
`define AXES              2
`define ERR_W             18
`define EVT_W             20
`define CMD_W             8
`define CMD_READ_ERR      8'hF2
`define CMD_READ_EVT      8'hF3
`define CMD_WRITE_EN      8'hAC
`define AXIS_MAIN_STATUS_WORD_W            16
`define AXIS_MAIN_STATUS_WORD_STOP_BIT     2
`define AXIS_MAIN_STATUS_WORD_ERR_BIT      4
`define AXIS_MAIN_STATUS_WORD_EVT_BIT      5
`define ENV1_MASK_BIT     29
`define ENV2_STOP_EN_BIT  27
`define PRMD_SUPPR_BIT    7
`define ERR_RSVD_BIT      11
`define EN_RESET          20'h00000
`endif

/* src/axis_irq_pkg.sv */
// types for the two-axis interrupt output logic
// assumes the defines header is on the include path
`include "axis_irq_defines.svh"
package axis_irq_pkg;
  typedef logic [`ERR_W-1:0] err_vec_t;
  typedef logic [`EVT_W-1:0] evt_vec_t;
endpackage

/* src/axis_irq_channel.sv */
// one axis: cause registers, enable register and summary flags
// assumes cause pulses, commands and strobes are one-cycle pulses on ref_clk_in
`include "axis_irq_defines.svh"
module axis_irq_channel (
  input  wire logic                    ref_clk_in,
  input  wire logic                    arst_n_in,
  input  wire axis_irq_pkg::err_vec_t  err_set_in,
  input  wire axis_irq_pkg::evt_vec_t  evt_set_in,
  input  wire logic                    stop_event_in,
  input  wire logic                    stop_en_in,
  input  wire logic                    suppress_in,
  input  wire logic                    cmd_read_err_in,
  input  wire logic                    cmd_read_evt_in,
  input  wire logic                    cmd_write_en_in,
  input  wire logic                    axis_main_status_word_read_in,
  input  wire axis_irq_pkg::evt_vec_t  buf_in,
  output logic                         stop_flag_out,
  output logic                         err_flag_out,
  output logic                         evt_flag_out,
  output axis_irq_pkg::err_vec_t       err_cause_out,
  output axis_irq_pkg::evt_vec_t       evt_cause_out,
  output axis_irq_pkg::evt_vec_t       evt_enable_out
);
  axis_irq_pkg::err_vec_t error_cause_reg;
  axis_irq_pkg::evt_vec_t event_cause_reg;
  axis_irq_pkg::evt_vec_t event_enable_reg;
  logic                   stop_flag;
  axis_irq_pkg::err_vec_t next_error_cause_reg;
  axis_irq_pkg::evt_vec_t next_event_cause_reg;
  axis_irq_pkg::evt_vec_t next_event_enable_reg;
  logic                   next_stop_flag;
  axis_irq_pkg::err_vec_t err_mask;

  always_comb begin
    err_mask = '1;
    err_mask[`ERR_RSVD_BIT] = 1'b0;
    // a read clears the register, but a cause arriving in the same cycle survives
    next_error_cause_reg = cmd_read_err_in ? '0 : error_cause_reg;
    next_error_cause_reg = next_error_cause_reg | (err_set_in & err_mask);
    // event causes only latch while enabled; set wins over the read clear
    next_event_cause_reg = cmd_read_evt_in ? '0 : event_cause_reg;
    next_event_cause_reg = next_event_cause_reg | (evt_set_in & event_enable_reg);
    next_event_enable_reg = cmd_write_en_in ? buf_in : event_enable_reg;
    next_stop_flag = axis_main_status_word_read_in ? 1'b0 : stop_flag;
    if (stop_event_in && stop_en_in && !suppress_in) begin
      next_stop_flag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      error_cause_reg  <= '0;
      event_cause_reg  <= '0;
      event_enable_reg <= `EN_RESET;
      stop_flag        <= 1'b0;
    end else begin
      error_cause_reg  <= next_error_cause_reg;
      event_cause_reg  <= next_event_cause_reg;
      event_enable_reg <= next_event_enable_reg;
      stop_flag        <= next_stop_flag;
    end
  end

  assign stop_flag_out  = stop_flag;
  assign err_flag_out   = |error_cause_reg;
  assign evt_flag_out   = |event_cause_reg;
  assign err_cause_out  = error_cause_reg;
  assign evt_cause_out  = event_cause_reg;
  assign evt_enable_out = event_enable_reg;
endmodule

/* testbench/axis_irq_sva.sv */
// checker for flag, pin and buffer timing at the top ports
// assumes a bind from tb_top
module axis_irq_sva (
  input wire logic        ref_clk_in,
  input wire logic        arst_n_in,
  input wire logic [1:0]  axis_sel_in,
  input wire logic        cmd_valid_in,
  input wire logic [7:0]  cmd_code_in,
  input wire logic [31:0] buf_in,
  input wire logic [1:0]  env1_write_in,
  input wire logic [1:0]  axis_main_status_word_read_in,
  input wire logic [35:0] err_set_in,
  input wire logic [1:0]  axis_operating_out_in,
  input wire logic        irq_n_out,
  input wire logic        buf_load_out,
  input wire logic [31:0] buf_data_out,
  input wire logic [31:0] axis_main_status_word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic        m1, m2, o1, o2, rd_err;
  logic [31:0] st;
  assign st = axis_main_status_word_out;
  assign rd_err = cmd_valid_in && axis_sel_in == 2'h1 && cmd_code_in == 8'hF2;
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {m1, m2, o1, o2} <= 4'h3;
    end else begin
      m1 <= env1_write_in[0] ? buf_in[29] : m1;
      m2 <= m1;
      o1 <= axis_operating_out_in[0];
      o2 <= o1;
    end
  end
  pin_follows_flags_a: assert property (irq_n_out == !(|(st & 32'h00340034) && !m2))
    else $error("irq pin wrong");
  err_flag_set_a: assert property (|(err_set_in[17:0] & 18'h3F7FF) ##1 !cmd_valid_in |=> st[4])
    else $error("error flag missing");
  err_flag_clear_a: assert property (rd_err && err_set_in[17:0] == 18'h0 |-> ##2 !st[4])
    else $error("error flag kept");
  buf_load_a: assert property (rd_err |=> buf_load_out)
    else $error("no buffer load");
  no_load_a: assert property (!cmd_valid_in |=> !buf_load_out)
    else $error("stray buffer load");
  err_copy_a: assert property (rd_err |=> buf_data_out[31:18] == 14'h0 && !buf_data_out[11])
    else $error("error copy bits wrong");
  stop_clear_a: assert property (axis_main_status_word_read_in[0] && !(o1 | o2 | axis_operating_out_in[0]) |-> ##2 !st[2])
    else $error("stop flag kept");
  status_bits_a: assert property ((st & 32'hFFCBFFCB) == 32'h0)
    else $error("stray status bit");
  cover property (rd_err);
  cover property (m2 && |(st & 32'h00340034));
  cover property ($rose(st[2]));
endmodule

/* testbench/axis_host_model.sv */
// host model: command strobes, status reads and the service routine
// assumes it drives on falling edges of ref_clk_in
module axis_host_model (
  input  wire logic        ref_clk_in,
  input  wire logic [31:0] status_in,
  output logic [1:0]       axis_sel_out,
  output logic             cmd_valid_out,
  output logic [7:0]       cmd_code_out,
  output logic [1:0]       axis_main_status_word_read_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    axis_sel_out = 2'h0;
    cmd_valid_out = 1'b0;
    cmd_code_out = 8'h00;
    axis_main_status_word_read_out = 2'h0;
  end
  task automatic cmd(input int a, input logic [7:0] code);
    @(negedge ref_clk_in);
    axis_sel_out = a[0] ? 2'h2 : 2'h1;
    cmd_code_out = code;
    cmd_valid_out = 1'b1;
    @(negedge ref_clk_in);
    cmd_valid_out = 1'b0;
  endtask
  task automatic rd_axis_main_status_word(input int a);
    @(negedge ref_clk_in);
    axis_main_status_word_read_out = a[0] ? 2'h2 : 2'h1;
    @(negedge ref_clk_in);
    axis_main_status_word_read_out = 2'h0;
  endtask
  task automatic service;
    logic [15:0] s;
    for (int a = 0; a < 2; a++) begin
      s = status_in[a*16 +: 16];
      rd_axis_main_status_word(a);
      if (s[4]) cmd(a, 8'hF2);
      if (s[5]) cmd(a, 8'hF3);
    end
  endtask
endmodule

/* testbench/tb_top.sv */
// bench: drives the interrupt output logic and compares with a flag model
// assumes the host model issues commands and status reads
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in, arst_n_in, cmd_valid_in, irq_n_out, buf_load_out;
  logic [1:0] axis_sel_in, env1_write_in, env2_write_in, prmd_write_in, axis_main_status_word_read_in;
  logic [1:0] axis_operating_out_in, next_op_queued_in, start_written_in;
  logic [7:0] cmd_code_in;
  logic [31:0] buf_in, buf_data_out, axis_main_status_word_out, r;
  logic [35:0] err_set_in;
  logic [39:0] evt_set_in;
  int ec[2], vc[2], sf[2], en[2], sten[2], sup[2];
  int mask, errors, checks;
  axis_interrupt_output_logic dut (.ref_clk_in, .arst_n_in, .axis_sel_in, .cmd_valid_in,
    .cmd_code_in, .buf_in, .env1_write_in, .env2_write_in, .prmd_write_in, .axis_main_status_word_read_in,
    .err_set_in, .evt_set_in, .axis_operating_out_in, .next_op_queued_in,
    .start_written_in, .irq_n_out, .buf_load_out, .buf_data_out, .axis_main_status_word_out);
  axis_host_model host (.ref_clk_in, .status_in(axis_main_status_word_out),
    .axis_sel_out(axis_sel_in), .cmd_valid_out(cmd_valid_in), .cmd_code_out(cmd_code_in),
    .axis_main_status_word_read_out(axis_main_status_word_read_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_all;
    logic [31:0] s;
    repeat (3) @(negedge ref_clk_in);
    s = 32'h0;
    for (int a = 0; a < 2; a++) begin
      s[a*16+2] = sf[a] != 0;
      s[a*16+4] = ec[a] != 0;
      s[a*16+5] = vc[a] != 0;
    end
    cmp("status", s, axis_main_status_word_out);
    cmp("irq_n", {31'h0, !(|s && mask == 0)}, {31'h0, irq_n_out});
  endtask
  task automatic cause(input int a, input logic [19:0] ev, input logic [17:0] er);
    @(negedge ref_clk_in);
    err_set_in[a*18 +: 18] = er;
    evt_set_in[a*20 +: 20] = ev;
    @(negedge ref_clk_in);
    err_set_in = '0;
    evt_set_in = '0;
    ec[a] |= er & 18'h3F7FF;
    vc[a] |= ev & en[a];
  endtask
  task automatic wr(input int k, input int a, input logic [31:0] v);
    @(negedge ref_clk_in);
    buf_in = v;
    if (k == 3) host.cmd(a, 8'hAC);
    else begin
      env1_write_in[a] = k == 0;
      env2_write_in[a] = k == 1;
      prmd_write_in[a] = k == 2;
      @(negedge ref_clk_in);
      {env1_write_in, env2_write_in, prmd_write_in} = 6'h00;
    end
    if (k == 0 && a == 0) mask = v[29];
    if (k == 1) sten[a] = v[27];
    if (k == 2) sup[a] = v[7];
    if (k == 3) en[a] = v[19:0];
  endtask
  task automatic rd_cause(input int a, input logic [7:0] code);
    logic [31:0] exp;
    exp = code == 8'hF2 ? ec[a] : vc[a];
    host.cmd(a, code);
    cmp("buf_load", 32'h1, {31'h0, buf_load_out});
    cmp("buf_data", exp, buf_data_out);
    if (code == 8'hF2) ec[a] = 0;
    else vc[a] = 0;
  endtask
  task automatic stop_axis(input int a, input logic q, input logic s);
    @(negedge ref_clk_in);
    axis_operating_out_in[a] = 1'b1;
    next_op_queued_in[a] = q;
    start_written_in[a] = s;
    repeat (2) @(negedge ref_clk_in);
    axis_operating_out_in[a] = 1'b0;
    sf[a] |= sten[a] != 0 && !(sup[a] != 0 && q && s);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    arst_n_in = 1'b0;
    buf_in = 32'h0;
    {env1_write_in, env2_write_in, prmd_write_in} = 6'h00;
    {axis_operating_out_in, next_op_queued_in, start_written_in} = 6'h00;
    err_set_in = '0;
    evt_set_in = '0;
    void'($urandom(7653));
    repeat (5) @(negedge ref_clk_in);
    arst_n_in = 1'b1;
    check_all;
    for (int a = 0; a < 2; a++) begin
      r = $urandom;
      cause(a, 20'h0, r[17:0] | 18'h1);
      check_all;
      rd_cause(a, 8'hF2);
      check_all;
    end
    cause(0, 20'h0, 18'h00800);
    check_all;
    r = $urandom;
    cause(1, r[19:0], 18'h0);
    check_all;
    for (int a = 0; a < 2; a++) begin
      wr(3, a, $urandom);
      r = $urandom;
      cause(a, r[19:0], 18'h0);
      check_all;
      rd_cause(a, 8'hF3);
      check_all;
    end
    wr(0, 0, 32'h20000000);
    cause(1, 20'h0, 18'h4);
    check_all;
    wr(0, 0, 32'h0);
    check_all;
    wr(1, 0, 32'h08000000);
    stop_axis(0, 1'b0, 1'b0);
    check_all;
    host.rd_axis_main_status_word(0);
    sf[0] = 0;
    check_all;
    stop_axis(1, 1'b0, 1'b0);
    check_all;
    wr(2, 0, 32'h80);
    stop_axis(0, 1'b1, 1'b1);
    check_all;
    stop_axis(0, 1'b1, 1'b0);
    check_all;
    cause(0, 20'hFFFFF, 18'h3);
    r = buf_in;
    for (int k = 0; k < 4 && irq_n_out !== 1'b1; k++) begin
      host.service;
      repeat (3) @(negedge ref_clk_in);
    end
    buf_in = r;
    cmp("service", 32'h1, {31'h0, irq_n_out});
    ec = '{0, 0};
    vc = '{0, 0};
    sf = '{0, 0};
    check_all;
    complete_run;
  end
endmodule
bind axis_interrupt_output_logic axis_irq_sva chk (.ref_clk_in, .arst_n_in, .axis_sel_in,
  .cmd_valid_in, .cmd_code_in, .buf_in, .env1_write_in, .axis_main_status_word_read_in, .err_set_in,
  .axis_operating_out_in, .irq_n_out, .buf_load_out, .buf_data_out,
  .axis_main_status_word_out);
